// *** logic/dip_pkg.sv ***
// package of constants and types shared by both stream ends
package dip_pkg;
   localparam int PIX_W          = 24;
   localparam int DIM_W          = 12;
   localparam int LINE_W_DEF     = 1024;
   localparam int LOG2_LINE_DEF  = 10;
   localparam bit EVEN_POL_DEF   = 1'b0;
   localparam int BUF_DEPTH      = 2;
   localparam logic [PIX_W-1:0] PIX_ZERO = 24'h000000;
   localparam logic [DIM_W-1:0] DIM_ZERO = 12'h000;
   localparam logic [DIM_W-1:0] DIM_ONE  = 12'h001;

   typedef enum logic [1:0] {
      DIP_IDLE  = 2'b00,
      DIP_FILL  = 2'b01,
      DIP_EMIT  = 2'b10
   } dip_state_t;

   typedef enum logic [1:0] {
      DIP_SRC_IDLE = 2'b00,
      DIP_SRC_RUN  = 2'b01
   } dip_src_state_t;

   function automatic logic [DIM_W-1:0] dip_inc(input logic [DIM_W-1:0] v);
      return v + DIM_ONE;
   endfunction
endpackage

// *** logic/dip_if.sv ***
// interface joining the video source, deinterlacer and sink
`timescale 1ns/1ps
interface dip_if;
   import dip_pkg::*;
   logic [PIX_W-1:0] in_pix;
   logic             in_field;
   logic             in_vsync;
   logic             in_hsync;
   logic             in_valid;
   logic             in_ready;
   logic [PIX_W-1:0] out_pix;
   logic             out_vsync;
   logic             out_hsync;
   logic             out_valid;

   modport device (input in_pix, input in_field, input in_vsync, input in_hsync, input in_valid,
                   output in_ready, output out_pix, output out_vsync, output out_hsync, output out_valid);
   modport host   (output in_pix, output in_field, output in_vsync, output in_hsync, output in_valid,
                   input in_ready, input out_pix, input out_vsync, input out_hsync, input out_valid);
endinterface

// *** logic/dip_device.sv ***
// deinterlacer end: field in, progressive frame out (line doubling)
`timescale 1ns/1ps
module dip_device
   import dip_pkg::*;
#(
   parameter int LINE_W    = LINE_W_DEF,
   parameter int LOG2_LINE = LOG2_LINE_DEF,
   parameter bit EVEN_POL  = EVEN_POL_DEF
) (
   input  wire logic             clk,
   input  wire logic             arst_n,
   input  wire logic             clk_en,
   input  wire logic [DIM_W-1:0] pixels_per_line,
   dip_if.device                 vid,
   output logic                  field_even,
   output logic                  active
);
   // refused at elaboration: the store must be a power of two the column counters reach
   if (LINE_W != (1 << LOG2_LINE) || LOG2_LINE < 4 || LOG2_LINE > DIM_W) begin
      $error("dip_device: bad line store size");
   end

   // ---------------------------------------------
   // input skid buffer (two entries)
   // ---------------------------------------------
   logic [PIX_W+2:0] buf_mem [BUF_DEPTH];
   logic [1:0]       cnt_reg, cnt_next;
   logic             wp_reg, wp_next, rp_reg, rp_next;
   logic             rdy_reg, rdy_next;
   logic             push, pop;
   logic [PIX_W+2:0] head;

   assign push = vid.in_valid && rdy_reg;
   assign head = buf_mem[rp_reg];

   always_comb begin
      cnt_next = cnt_reg;
      wp_next  = wp_reg;
      rp_next  = rp_reg;
      if (push) begin
         wp_next = ~wp_reg;
      end
      if (pop) begin
         rp_next = ~rp_reg;
      end
      case ({push, pop})
         2'b10:   cnt_next = cnt_reg + 2'h1;
         2'b01:   cnt_next = cnt_reg - 2'h1;
         default: cnt_next = cnt_reg;
      endcase
      // ready registered: leave room for the word in flight
      rdy_next = (cnt_next == 2'h0) || (cnt_next == 2'h1 && !push);
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_reg <= 2'h0;
         wp_reg  <= 1'b0;
         rp_reg  <= 1'b0;
         rdy_reg <= 1'b0;
      end else if (clk_en) begin
         cnt_reg <= cnt_next;
         wp_reg  <= wp_next;
         rp_reg  <= rp_next;
         rdy_reg <= rdy_next;
      end
   end

   always_ff @(posedge clk) begin
      if (clk_en && push) begin
         buf_mem[wp_reg] <= {vid.in_field, vid.in_vsync, vid.in_hsync, vid.in_pix};
      end
   end

   // ---------------------------------------------
   // line store and doubling engine
   // ---------------------------------------------
   logic [PIX_W-1:0] line_mem [LINE_W];
   dip_state_t       st_reg, st_next;
   logic [DIM_W-1:0] wcol_reg, wcol_next, rcol_reg, rcol_next;
   logic             vs_pend_reg, vs_pend_next, pass_reg, pass_next;
   logic             even_reg, even_next, act_reg, act_next;
   logic [PIX_W-1:0] opix_reg, opix_next;
   logic             ov_reg, ov_next, ovs_reg, ovs_next, ohs_reg, ohs_next;
   logic             h_vs, h_hs, h_fld, wr_en;
   logic [DIM_W-1:0] npix;
   logic             realign;

   assign h_fld = head[PIX_W+2];
   assign h_vs  = head[PIX_W+1];
   assign h_hs  = head[PIX_W];
   assign npix  = (pixels_per_line == DIM_ZERO) ? DIM_ONE : pixels_per_line;
   // an hsync before the line is full throws the partial line away
   assign realign = h_hs && (wcol_reg != DIM_ZERO);

   always_comb begin
      st_next      = st_reg;
      wcol_next    = wcol_reg;
      rcol_next    = rcol_reg;
      vs_pend_next = vs_pend_reg;
      pass_next    = pass_reg;
      even_next    = even_reg;
      act_next     = act_reg;
      opix_next    = opix_reg;
      ov_next      = 1'b0;
      ovs_next     = 1'b0;
      ohs_next     = 1'b0;
      pop          = 1'b0;
      wr_en        = 1'b0;
      case (st_reg)
         DIP_IDLE: begin
            if (cnt_reg != 2'h0) begin
               pop = 1'b1;
               if (h_vs) begin
                  act_next     = 1'b1;
                  even_next    = (h_fld == EVEN_POL);
                  vs_pend_next = 1'b1;
                  wr_en        = 1'b1;
                  wcol_next    = DIM_ONE;
                  st_next      = (npix == DIM_ONE) ? DIP_EMIT : DIP_FILL;
               end
            end
         end
         DIP_FILL: begin
            if (cnt_reg != 2'h0) begin
               pop   = 1'b1;
               wr_en = 1'b1;
               if (h_vs) begin
                  even_next    = (h_fld == EVEN_POL);
                  vs_pend_next = 1'b1;
               end
               // re-align on an early sync: start the line over
               wcol_next = realign ? DIM_ONE : dip_inc(wcol_reg);
               if (dip_inc(wcol_reg) == npix && !realign) begin
                  st_next   = DIP_EMIT;
                  rcol_next = DIM_ZERO;
                  pass_next = 1'b0;
               end
            end
         end
         DIP_EMIT: begin
            // two output lines per input line; no stall possible downstream
            ov_next   = 1'b1;
            opix_next = line_mem[rcol_reg[LOG2_LINE-1:0]];
            ohs_next  = (rcol_reg == DIM_ZERO);
            ovs_next  = (rcol_reg == DIM_ZERO) && !pass_reg && vs_pend_reg;
            if (rcol_reg == DIM_ZERO && !pass_reg) begin
               vs_pend_next = 1'b0;
            end
            rcol_next = dip_inc(rcol_reg);
            if (dip_inc(rcol_reg) == npix) begin
               rcol_next = DIM_ZERO;
               pass_next = ~pass_reg;
               if (pass_reg) begin
                  st_next   = DIP_FILL;
                  wcol_next = DIM_ZERO;
               end
            end
         end
         default: st_next = DIP_IDLE;
      endcase
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         st_reg      <= DIP_IDLE;
         wcol_reg    <= DIM_ZERO;
         rcol_reg    <= DIM_ZERO;
         vs_pend_reg <= 1'b0;
         pass_reg    <= 1'b0;
         even_reg    <= 1'b0;
         act_reg     <= 1'b0;
         opix_reg    <= PIX_ZERO;
         ov_reg      <= 1'b0;
         ovs_reg     <= 1'b0;
         ohs_reg     <= 1'b0;
      end else if (clk_en) begin
         st_reg      <= st_next;
         wcol_reg    <= wcol_next;
         rcol_reg    <= rcol_next;
         vs_pend_reg <= vs_pend_next;
         pass_reg    <= pass_next;
         even_reg    <= even_next;
         act_reg     <= act_next;
         opix_reg    <= opix_next;
         ov_reg      <= ov_next;
         ovs_reg     <= ovs_next;
         ohs_reg     <= ohs_next;
      end
   end

   always_ff @(posedge clk) begin
      if (clk_en && wr_en) begin
         line_mem[(st_reg == DIP_IDLE || realign) ? '0
                  : wcol_reg[LOG2_LINE-1:0]] <= head[PIX_W-1:0];
      end
   end

   // no field flag on the output stream; parity leaves only on field_even
   assign vid.in_ready  = rdy_reg;
   assign vid.out_pix   = opix_reg;
   assign vid.out_vsync = ovs_reg;
   assign vid.out_hsync = ohs_reg;
   assign vid.out_valid = ov_reg;
   assign field_even    = even_reg;
   assign active        = act_reg;
endmodule

// *** logic/dip_host.sv ***
// far end: interlaced pixel source and progressive sink
`timescale 1ns/1ps
module dip_host
   import dip_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             arst_n,
   input  wire logic             clk_en,
   input  wire logic [PIX_W-1:0] src_pix,
   input  wire logic             src_field,
   input  wire logic             src_sof,
   input  wire logic             src_sol,
   input  wire logic             src_valid,
   output logic                  src_ready,
   output logic [PIX_W-1:0]      snk_pix,
   output logic                  snk_vsync,
   output logic                  snk_hsync,
   output logic                  snk_valid,
   dip_if.host                   vid
);
   // ---------------------------------------------
   // source side: one holding register
   // ---------------------------------------------
   logic [PIX_W-1:0] pix_reg, pix_next;
   logic             fld_reg, fld_next, vs_reg, vs_next, hs_reg, hs_next;
   logic             v_reg, v_next;
   logic [PIX_W-1:0] spix_reg, spix_next;
   logic             svs_reg, svs_next, shs_reg, shs_next, sv_reg, sv_next;

   always_comb begin
      pix_next = pix_reg;
      fld_next = fld_reg;
      vs_next  = vs_reg;
      hs_next  = hs_reg;
      v_next   = v_reg;
      if (v_reg && vid.in_ready) begin
         v_next = 1'b0;
      end
      // hold word until accepted
      if (!v_next && src_valid) begin
         v_next   = 1'b1;
         pix_next = src_pix;
         fld_next = src_field;
         vs_next  = src_sof;
         hs_next  = src_sol | src_sof;
      end
      // sink always takes what is valid
      sv_next   = vid.out_valid;
      spix_next = vid.out_pix;
      svs_next  = vid.out_valid && vid.out_vsync;
      shs_next  = vid.out_valid && vid.out_hsync;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pix_reg  <= PIX_ZERO;
         fld_reg  <= 1'b0;
         vs_reg   <= 1'b0;
         hs_reg   <= 1'b0;
         v_reg    <= 1'b0;
         spix_reg <= PIX_ZERO;
         svs_reg  <= 1'b0;
         shs_reg  <= 1'b0;
         sv_reg   <= 1'b0;
      end else if (clk_en) begin
         pix_reg  <= pix_next;
         fld_reg  <= fld_next;
         vs_reg   <= vs_next;
         hs_reg   <= hs_next;
         v_reg    <= v_next;
         spix_reg <= spix_next;
         svs_reg  <= svs_next;
         shs_reg  <= shs_next;
         sv_reg   <= sv_next;
      end
   end

   assign vid.in_pix   = pix_reg;
   assign vid.in_field = fld_reg;
   assign vid.in_vsync = vs_reg;
   assign vid.in_hsync = hs_reg;
   assign vid.in_valid = v_reg;
   assign src_ready    = !v_reg || vid.in_ready;
   assign snk_pix      = spix_reg;
   assign snk_vsync    = svs_reg;
   assign snk_hsync    = shs_reg;
   assign snk_valid    = sv_reg;
endmodule

// *** dv/dip_monitor.sv ***
// assertions and covers on the stream joining the two ends
`timescale 1ns/1ps
module dip_monitor
   import dip_pkg::*;
(
   input wire logic             clk,
   input wire logic             arst_n,
   input wire logic [PIX_W-1:0] in_pix,
   input wire logic             in_field,
   input wire logic             in_vsync,
   input wire logic             in_hsync,
   input wire logic             in_valid,
   input wire logic             in_ready,
   input wire logic [PIX_W-1:0] out_pix,
   input wire logic             out_vsync,
   input wire logic             out_hsync,
   input wire logic             out_valid
);
   logic seen_vs_reg;
   logic seen_vs_next;
   always_comb begin
      seen_vs_next = seen_vs_reg | (in_valid & in_ready & in_vsync);
   end
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         seen_vs_reg <= 1'b0;
      end else begin
         seen_vs_reg <= seen_vs_next;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   // ----------------------------------------
   // figures assume a two-pixel line
   // ----------------------------------------
   a_reset_quiet: assert property ($rose(arst_n) |-> !out_valid && !in_ready)
      else $error("output active at reset release");
   a_vs_with_hs: assert property (out_valid && out_vsync |-> out_hsync)
      else $error("frame start without line start");
   a_hs_spacing: assert property (out_valid && out_hsync |=> out_valid && !out_hsync)
      else $error("line start not followed by pixel");
   a_vs_once: assert property (out_valid && out_vsync |-> ##1 !out_vsync [*3])
      else $error("repeated frame start");
   a_line_repeat: assert property (out_valid && out_vsync |-> ##2 out_valid && out_hsync
      && out_pix == $past(out_pix, 2))
      else $error("line not doubled");
   a_gate_first: assert property (out_valid |-> seen_vs_reg)
      else $error("output before first frame start");
   a_hold_stall: assert property (in_valid && !in_ready |=> in_valid && $stable(in_pix)
      && $stable(in_field) && $stable(in_vsync) && $stable(in_hsync))
      else $error("source moved while stalled");
   a_field_start: assert property (in_valid && in_vsync |-> in_hsync)
      else $error("field start without line start");
   c_stall: cover property (in_valid && !in_ready);
   c_in_vs: cover property (in_valid && in_ready && in_vsync);
   c_out_vs: cover property (out_valid && out_vsync);
   c_out_repeat: cover property (out_valid && out_hsync && !out_vsync);
endmodule

// *** dv/dip_device_tb.sv ***
// self-checking bench: source feeds two fields, sink output compared
`timescale 1ns/1ps
module dip_device_tb;
   import dip_pkg::*;
   typedef logic [PIX_W+1:0] dip_word_t;
   logic             clk;
   logic             arst_n;
   logic [PIX_W-1:0] src_pix;
   logic             src_field, src_sof, src_sol, src_valid, src_ready;
   logic [PIX_W-1:0] snk_pix;
   logic             snk_vsync, snk_hsync, snk_valid, field_even, active;
   int               num_errors, n_checks, cyc;
   dip_word_t        got[$];
   dip_word_t        exp_q[$];
   dip_if vid();
   dip_device u_dip_device (.clk(clk), .arst_n(arst_n), .clk_en(1'b1), .pixels_per_line(12'h002),
      .vid(vid), .field_even(field_even), .active(active));
   dip_host u_dip_host (.clk(clk), .arst_n(arst_n), .clk_en(1'b1), .src_pix(src_pix), .src_field(src_field),
      .src_sof(src_sof), .src_sol(src_sol), .src_valid(src_valid), .src_ready(src_ready), .snk_pix(snk_pix),
      .snk_vsync(snk_vsync), .snk_hsync(snk_hsync), .snk_valid(snk_valid), .vid(vid));
   dip_monitor u_dip_monitor (.clk(clk), .arst_n(arst_n), .in_pix(vid.in_pix), .in_field(vid.in_field),
      .in_vsync(vid.in_vsync), .in_hsync(vid.in_hsync), .in_valid(vid.in_valid), .in_ready(vid.in_ready),
      .out_pix(vid.out_pix), .out_vsync(vid.out_vsync), .out_hsync(vid.out_hsync), .out_valid(vid.out_valid));
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task automatic chk(input dip_word_t seen, input dip_word_t expv);
      n_checks++;
      if (seen !== expv) begin
         num_errors++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, expv);
      end
   endtask
   // held until the source side reports ready at a falling edge
   task automatic send(input logic [PIX_W-1:0] p, input logic sof, input logic sol, input logic f);
      @(negedge clk);
      {src_pix, src_sof, src_sol, src_field, src_valid} = {p, sof, sol, f, 1'b1};
      while (src_ready !== 1'b1) @(negedge clk);
   endtask
   // garbage with syncs high but valid low must be ignored
   task automatic idle(input int n);
      repeat (n) begin
         @(negedge clk);
         {src_pix, src_sof, src_sol, src_field, src_valid} = {24'hFFFFFF, 3'b111, 1'b0};
      end
   endtask
   task automatic t_reset();
      chk(dip_word_t'({snk_valid, active}), '0);
      send(24'h0000AA, 1'b0, 1'b1, 1'b0);
      idle(20);
      chk(dip_word_t'({got.size() == 0, active}), dip_word_t'(2'b10));
      $display("test reset done");
   endtask
   // two lines per field; later words carry the opposite field flag
   task automatic t_field(input logic f, input logic [PIX_W-1:0] b);
      got.delete();
      exp_q.delete();
      for (int l = 0; l < 2; l++) begin
         send(PIX_W'(b + 2 * l), l == 0, 1'b1, l == 0 ? f : !f);
         idle(2);
         send(PIX_W'(b + 2 * l + 1), 1'b0, 1'b0, !f);
         for (int k = 0; k < 4; k++) exp_q.push_back({l == 0 && k == 0, k % 2 == 0, PIX_W'(b + 2 * l + k % 2)});
      end
      idle(1);
      for (int i = 0; i < 400 && got.size() < exp_q.size(); i++) @(negedge clk);
      idle(10);
      chk(dip_word_t'(got.size()), dip_word_t'(exp_q.size()));
      foreach (exp_q[i]) chk(got[i], exp_q[i]);
      chk(dip_word_t'(field_even), dip_word_t'(f == EVEN_POL_DEF));
      chk(dip_word_t'(active), dip_word_t'(1'b1));
      $display("test field %0d done", f);
   endtask
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // sink outputs are settled by the falling edge
   always @(negedge clk) begin
      if (snk_valid === 1'b1) got.push_back({snk_vsync, snk_hsync, snk_pix});
      cyc++;
      if (cyc == 3000) begin
         num_errors++;
         end_sim();
      end
   end
   initial begin
      num_errors = 0;
      n_checks = 0;
      cyc = 0;
      arst_n = 1'b0;
      {src_pix, src_sof, src_sol, src_field, src_valid} = '0;
      repeat (6) @(posedge clk);
      @(negedge clk);
      arst_n = 1'b1;
      t_reset();
      t_field(1'b0, 24'h100000);
      t_field(1'b1, 24'h200000);
      end_sim();
   end
endmodule
